// ### rtl/lpc_io_target_cycle.sv
// LPC I/O target cycle sequencer, peripheral side
// Behaviour
// - In reset ignore frame, release LAD
// - I/O read inserts three wait states
// - I/O write inserts two wait states
// - Wait states use long-wait SYNC 0110
// - Last START 0000 with frame starts cycle
// - Type nibble: 00 is I/O, bit1 direction
// - Turnaround: host 1111 then nobody drives
// - Ready SYNC 0000, then read data nibbles
// - After read data drive 1111, then release
// - Frame asserted stops LAD drive, aborts cycle
`timescale 1ns/1ps
module lpc_io_target_cycle
(
    // Clock and LPC reset (high while reset is asserted)
    input wire logic clock,
    input wire logic rst,
    // LPC pins, synchronous to clock
    input wire logic frameN,
    input wire lpc_pkg::nib_t ladIn,
    output lpc_pkg::nib_t ladOut,
    output logic ladOeN,
    // Local register side
    output logic [15:0] ioAddr,
    output logic [7:0] ioWrData,
    output logic ioWrite,
    output logic ioRead,
    input wire logic [7:0] ioRdData
);
    import lpc_pkg::*;

    typedef enum logic [9:0] {
        S_IDLE  = 10'h001,
        S_CYC   = 10'h002,
        S_ADDR  = 10'h004,
        S_WDATA = 10'h008,
        S_TAR1  = 10'h010,
        S_TAR2  = 10'h020,
        S_WAIT  = 10'h040,
        S_READY = 10'h080,
        S_RDATA = 10'h100,
        S_TARB  = 10'h200
    } state_e;

    state_e st, next_st;
    logic [1:0] cnt, next_cnt;
    logic isWrite, next_isWrite;
    logic [15:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic [7:0] rdLatch, next_rdLatch;
    logic drive, next_drive;
    nib_t next_ladOut;
    logic next_ioWrite, next_ioRead;

    // Next state, field capture and LAD drive value
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_isWrite = isWrite;
        next_addr = addr;
        next_wdata = wdata;
        next_rdLatch = rdLatch;
        next_ioWrite = 1'b0;
        next_ioRead = 1'b0;
        if (!frameN)
        begin
            // Frame low: abort, and restart on each START nibble
            next_st = (ladIn == START_IO) ? S_CYC : S_IDLE;
        end
        else
        begin
            unique case (st)
                S_IDLE: next_st = S_IDLE;
                S_CYC:
                begin
                    // Only I/O cycles are claimed, others ignored
                    if (ladIn[3:2] == TYPE_IO)
                    begin
                        next_st = S_ADDR;
                        next_isWrite = ladIn[DIR_BIT];
                        next_cnt = 2'h0;
                    end
                    else
                    begin
                        next_st = S_IDLE;
                    end
                end
                S_ADDR:
                begin
                    next_addr = {addr[11:0], ladIn};
                    next_cnt = cnt + 2'h1;
                    if (cnt == ADDR_LAST)
                    begin
                        next_cnt = 2'h0;
                        next_st = isWrite ? S_WDATA : S_TAR1;
                    end
                end
                S_WDATA:
                begin
                    // Low nibble arrives first
                    if (cnt == 2'h0)
                    begin
                        next_wdata = {wdata[7:4], ladIn};
                        next_cnt = 2'h1;
                    end
                    else
                    begin
                        next_wdata = {ladIn, wdata[3:0]};
                        next_cnt = 2'h0;
                        next_st = S_TAR1;
                    end
                end
                S_TAR1: next_st = S_TAR2;
                S_TAR2:
                begin
                    next_st = S_WAIT;
                    next_cnt = 2'h1;
                    next_ioRead = !isWrite;
                end
                S_WAIT:
                begin
                    next_cnt = cnt + 2'h1;
                    if (cnt == (isWrite ? WRITE_WAITS : READ_WAITS))
                    begin
                        next_st = S_READY;
                        next_cnt = 2'h0;
                        next_rdLatch = ioRdData;
                        next_ioWrite = isWrite;
                    end
                end
                S_READY: next_st = isWrite ? S_TARB : S_RDATA;
                S_RDATA:
                begin
                    next_cnt = 2'h1;
                    if (cnt == 2'h1)
                    begin
                        next_cnt = 2'h0;
                        next_st = S_TARB;
                    end
                end
                S_TARB: next_st = S_IDLE;
                default: next_st = S_IDLE;
            endcase
        end
        // Drive value follows the next state so it is registered
        unique case (next_st)
            S_WAIT: next_ladOut = SYNC_LONG;
            S_READY: next_ladOut = SYNC_READY;
            S_RDATA: next_ladOut = (next_cnt == 2'h0) ? rdLatch[3:0] : rdLatch[7:4];
            S_TARB: next_ladOut = TAR_HIGH;
            default: next_ladOut = TAR_HIGH;
        endcase
        next_drive = (next_st == S_WAIT) || (next_st == S_READY)
            || (next_st == S_RDATA) || (next_st == S_TARB);
    end

    // State registers; synchronous reset
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            st <= S_IDLE;
            cnt <= 2'h0;
            isWrite <= 1'b0;
            addr <= ADDR_RESET;
            wdata <= DATA_RESET;
            rdLatch <= DATA_RESET;
            drive <= 1'b0;
            ladOut <= TAR_HIGH;
            ioWrite <= 1'b0;
            ioRead <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            isWrite <= next_isWrite;
            addr <= next_addr;
            wdata <= next_wdata;
            rdLatch <= next_rdLatch;
            drive <= next_drive;
            ladOut <= next_ladOut;
            ioWrite <= next_ioWrite;
            ioRead <= next_ioRead;
        end
    end

    // Output enable low while driving; frame or reset releases at once
    assign ladOeN = !(drive && frameN && !rst);
    assign ioAddr = addr;
    assign ioWrData = wdata;

    // Checks
    reset_release_a: assert property (@(posedge clock) rst |-> ladOeN)
        else $error("LAD driven during reset");
    abort_release_a: assert property (@(posedge clock) !frameN |-> ladOeN)
        else $error("LAD driven while frame asserted");
    start_detect_a: assert property (@(posedge clock) disable iff (rst)
        (!frameN && ladIn == START_IO) |=> st == S_CYC)
        else $error("START not taken");
    type_reject_a: assert property (@(posedge clock) disable iff (rst)
        (st == S_CYC && frameN && ladIn[3:2] != TYPE_IO) |=> st == S_IDLE && ladOeN)
        else $error("Non-I/O cycle claimed");
    addr_order_a: assert property (@(posedge clock) disable iff (rst)
        (st == S_ADDR && cnt == 2'h0 && frameN) ##1 frameN[*3] ##1 1'b1
        |-> addr == {$past(ladIn, 4), $past(ladIn, 3), $past(ladIn, 2), $past(ladIn, 1)})
        else $error("Address assembled wrongly");
    tar_quiet_a: assert property (@(posedge clock) disable iff (rst)
        (st == S_TAR1 || st == S_TAR2) |-> ladOeN)
        else $error("LAD driven during turnaround");
    read_waits_a: assert property (@(posedge clock) disable iff (rst || !frameN)
        (st == S_TAR2 && !isWrite && frameN)
        |=> (!ladOeN && ladOut == SYNC_LONG)[*3] ##1 (!ladOeN && ladOut == SYNC_READY))
        else $error("Read wait states wrong");
    write_waits_a: assert property (@(posedge clock) disable iff (rst || !frameN)
        (st == S_TAR2 && isWrite && frameN)
        |=> (!ladOeN && ladOut == SYNC_LONG)[*2] ##1 (!ladOeN && ladOut == SYNC_READY)
        ##1 (ladOut == TAR_HIGH) ##1 ladOeN)
        else $error("Write wait states wrong");
    read_data_a: assert property (@(posedge clock) disable iff (rst || !frameN)
        (st == S_READY && !isWrite)
        |=> (ladOut == rdLatch[3:0]) ##1 (ladOut == rdLatch[7:4])
        ##1 (ladOut == TAR_HIGH && !ladOeN) ##1 ladOeN)
        else $error("Read data phase wrong");
    write_strobe_a: assert property (@(posedge clock) disable iff (rst)
        ioWrite |-> st == S_READY && isWrite)
        else $error("Write strobe misplaced");

    read_done_c: cover property (@(posedge clock) disable iff (rst)
        st == S_RDATA ##1 st == S_TARB);
    write_done_c: cover property (@(posedge clock) disable iff (rst) ioWrite);
    abort_mid_c: cover property (@(posedge clock) disable iff (rst)
        st == S_WAIT && !frameN);
endmodule

// ### rtl/lpc_pkg.sv
// Constants and types shared by the LPC I/O target
package lpc_pkg;
    typedef logic [3:0] nib_t;
    localparam nib_t START_IO = 4'h0;
    localparam nib_t SYNC_LONG = 4'h6;
    localparam nib_t SYNC_READY = 4'h0;
    localparam nib_t TAR_HIGH = 4'hF;
    localparam logic [1:0] TYPE_IO = 2'h0;
    localparam int DIR_BIT = 1;
    localparam logic [1:0] READ_WAITS = 2'h3;
    localparam logic [1:0] WRITE_WAITS = 2'h2;
    localparam logic [1:0] ADDR_LAST = 2'h3;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Host side only: clock must run this long before reset release
    localparam int CLOCK_MHZ = 100;
    localparam int RESET_STABLE_US = 100;
    localparam int RESET_STABLE_CYCLES = RESET_STABLE_US * CLOCK_MHZ;
endpackage

// ### test/host_model.sv
// Host LPC controller model running I/O cycles
`timescale 1ns/1ps
module host_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Device drive of LAD
    input wire logic [3:0] ladOut,
    input wire logic ladOeN,
    // Bus wires
    output logic frameN,
    output logic [3:0] ladWire
);
    logic hostDrv = 1'b0;
    logic [3:0] hostLad = 4'hF;
    logic [3:0] lastLad = 4'hF;
    initial frameN = 1'b1;
    // Released lines show the inverse of their last value; host lets go in reset
    assign ladWire = (hostDrv && !rst) ? hostLad : (!ladOeN ? ladOut : ~lastLad);
    always @(posedge clock) lastLad <= ladWire;
    // One host nibble per clock, set at the falling edge
    task automatic put(input logic f, input logic [3:0] v);
        @(negedge clock);
        frameN = f;
        hostDrv = 1'b1;
        hostLad = v;
    endtask
    // Frame high, lines let go
    task automatic idle();
        @(negedge clock);
        frameN = 1'b1;
        hostDrv = 1'b0;
    endtask
    // Start, type, address, write data, then turnaround
    task automatic head(input logic wr, input logic [15:0] a, input logic [7:0] d);
        put(1'b0, 4'h0);
        put(1'b1, {2'b00, wr, 1'b0});
        for (int i = 3; i >= 0; i--)
            put(1'b1, a[i*4 +: 4]);
        if (wr)
        begin
            put(1'b1, d[3:0]);
            put(1'b1, d[7:4]);
        end
        put(1'b1, 4'hF);
        idle();
    endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the LPC I/O target sequencer
`timescale 1ns/1ps
module tb_top;
    import lpc_pkg::*;
    logic clock, rst, frameN, ladOeN, ioWrite, ioRead, r;
    nib_t ladWire, ladOut;
    logic [15:0] ioAddr, addr;
    logic [7:0] ioWrData, ioRdData, data;
    int nErrors, cmpCount, n;
    lpc_io_target_cycle i_lpc_io_target_cycle (.clock(clock), .rst(rst), .frameN(frameN),
        .ladIn(ladWire), .ladOut(ladOut), .ladOeN(ladOeN), .ioAddr(ioAddr),
        .ioWrData(ioWrData), .ioWrite(ioWrite), .ioRead(ioRead), .ioRdData(ioRdData));
    host_model i_host_model (.clock(clock), .rst(rst), .ladOut(ladOut), .ladOeN(ladOeN),
        .frameN(frameN), .ladWire(ladWire));
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Wait states expected for a direction
    function automatic logic [15:0] waits(input logic wr);
        return wr ? 16'h0002 : 16'h0003;
    endfunction
    // Value compare
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmpCount++;
        if (g !== e)
        begin
            nErrors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict
    task automatic results();
        $display("compares %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Settled sample after the falling edge
    task automatic step();
        @(negedge clock);
        #1;
    endtask
    // Bounded wait for the device to drive
    task automatic grab();
        n = 0;
        while (ladOeN !== 1'b0 && n < 4)
        begin
            step();
            n++;
        end
        if (ladOeN !== 1'b0)
        begin
            chk("drive", 16'h0000, 16'h0001);
            results();
        end
    endtask
    // Count cycles the device drives
    task automatic quiet(input int k);
        int c;
        c = 0;
        repeat (k)
        begin
            step();
            if (ladOeN !== 1'b1) c++;
        end
        chk("quiet", 16'h0000, c[15:0]);
    endtask
    // Full I/O cycle with device answer checked
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
        ioRdData = d;
        i_host_model.head(wr, a, d);
        #1;
        chk("tar", 16'h0001, 16'(ladOeN));
        grab();
        chk("ioRead", 16'(!wr), 16'(ioRead));
        n = 0;
        while (ladWire === SYNC_LONG && n < 9)
        begin
            step();
            n++;
        end
        chk("waits", waits(wr), n[15:0]);
        // A wait phase that never ends stops the run
        if (n == 9)
            results();
        chk("ready", 16'(SYNC_READY), 16'(ladWire));
        chk("ioAddr", a, ioAddr);
        if (wr)
        begin
            chk("ioWrite", 16'h0001, 16'(ioWrite));
            chk("ioWrData", 16'(d), 16'(ioWrData));
        end
        else
        begin
            step();
            chk("dataLo", 16'(d[3:0]), 16'(ladWire));
            step();
            chk("dataHi", 16'(d[7:4]), 16'(ladWire));
        end
        step();
        chk("tarOut", 16'(TAR_HIGH), 16'(ladWire));
        step();
        chk("free", 16'h0001, 16'(ladOeN));
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        ioRdData = 8'h00;
        nErrors = 0;
        cmpCount = 0;
        n = $urandom(32'hAB94);
        repeat (4) @(negedge clock);
        rst = 1'b0;
        xfer(1'b0, 16'hFFFF, 8'hA5);
        xfer(1'b1, 16'h0000, 8'h5A);
        repeat (10)
        begin
            r = 1'($urandom);
            addr = 16'($urandom);
            data = 8'($urandom);
            xfer(r, addr, data);
        end
        $display("test traffic done");
        i_host_model.put(1'b0, 4'h0);
        xfer(1'b1, 16'h1234, 8'hC3);
        $display("test restart done");
        i_host_model.put(1'b0, 4'h0);
        i_host_model.put(1'b1, 4'h4);
        quiet(12);
        $display("test type done");
        i_host_model.head(1'b0, 16'h0080, 8'h00);
        grab();
        i_host_model.put(1'b0, 4'hF);
        #1;
        chk("abort", 16'h0001, 16'(ladOeN));
        i_host_model.idle();
        quiet(12);
        xfer(1'b0, 16'h0081, 8'h3C);
        $display("test abort done");
        i_host_model.head(1'b0, 16'h0060, 8'h00);
        grab();
        rst = 1'b1;
        #1;
        chk("rstOe", 16'h0001, 16'(ladOeN));
        i_host_model.head(1'b0, 16'h0064, 8'h00);
        chk("rstOut", 16'(TAR_HIGH), 16'(ladOut));
        // Clock runs through the settle time before reset is let go
        repeat (RESET_STABLE_CYCLES) @(negedge clock);
        rst = 1'b0;
        quiet(12);
        xfer(1'b1, 16'h0065, 8'h96);
        $display("test reset done");
        results();
    end
endmodule
